/* pkg/ais_consts.svh */
/*
 status register constants: offsets, bit positions, reset values.
 assumes inclusion by bare name from package and design files.
*/
`ifndef AIS_CONSTS_SVH
`define AIS_CONSTS_SVH
`define AIS_STATUS_ADDR 6'h00
`define AIS_STATUS_RESET 8'h10
`define AIS_BIT_READY_N 7
`define AIS_BIT_ERR 6
`define AIS_BIT_RSVD 5
`define AIS_BIT_POR 4
`define AIS_CH_MSB 3
`define AIS_CH_W 4
`define AIS_CH_RESET 4'h0
`define AIS_ERR_W 16
`define AIS_DATA_W 16
`endif

/* pkg/ais_pkg.sv */
/*
 types shared by the status flag block.
 assumes ais_consts.svh is on the include path.
*/
`include "ais_consts.svh"
package ais_pkg;
    typedef logic [`AIS_CH_W-1:0] ais_chan_t;
    typedef logic [7:0] ais_status_t;
endpackage : ais_pkg

/* design/ais_sync2.sv */
/*
 two-flop synchroniser for a level from outside the clock domain.
 assumes a single clock and active-low async reset.
*/
`timescale 1ns/1ps
module ais_sync2 (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic d_i,
    output logic q_o
);
    logic stage1;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stage1 <= 1'b0;
            q_o <= 1'b0;
        end else begin
            stage1 <= d_i;
            q_o <= stage1;
        end
    end
endmodule : ais_sync2

/* design/adc_interface_status.sv */
/*
 low status flags of the converter status register: summary error, reset event,
 result channel index and the active-low data-ready flag.
 assumes the serial interface decodes reads and strobes status/data reads,
 and that converter, error register and serial interface share ref_clk_i.
 besides rst_n_i, the supply monitor is the only asynchronous input; it is synchronised here.
 limitation: a supply dip shorter than one clock period may be missed.
 status_o is a bundle of flops, so a read sees the flags of the previous edge.
*/
`timescale 1ns/1ps
`include "ais_consts.svh"
module adc_interface_status
    import ais_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [`AIS_ERR_W-1:0] error_flags_i,
    input wire logic supply_low_i,
    input wire logic result_write_i,
    input wire logic [`AIS_DATA_W-1:0] result_data_i,
    input wire logic [`AIS_CH_W-1:0] result_channel_i,
    input wire logic reg_read_i,
    input wire logic [5:0] reg_addr_i,
    input wire logic data_read_i,
    output logic [7:0] status_o,
    output logic [`AIS_DATA_W-1:0] data_o,
    output logic fifo_main_err_o,
    output logic result_ready_n_o
);
    logic rst_meta;
    logic rst_sync_n;
    logic supply_low_s;
    logic supply_low_d;
    logic main_err;
    logic por_flag;
    ais_chan_t result_channel_index;
    logic result_ready_n;
    logic [`AIS_DATA_W-1:0] data_reg;
    logic status_read;
    logic supply_dip;

    // reset released through two flops; assertion stays asynchronous
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // monitor pin crosses in through two flops before any logic reads it
    ais_sync2 u_supply_sync (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_sync_n),
        .d_i(supply_low_i),
        .q_o(supply_low_s)
    );

    always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            supply_low_d <= 1'b0;
        end else begin
            supply_low_d <= supply_low_s;
        end
    end

    // rising edge of the synchronised monitor marks one supply dip
    assign supply_dip = supply_low_s && !supply_low_d;

    assign status_read = reg_read_i && (reg_addr_i == `AIS_STATUS_ADDR);

    // error flag is a registered OR, so it drops on its own with the errors
    always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            main_err <= 1'b0;
            fifo_main_err_o <= 1'b0;
        end else begin
            main_err <= |error_flags_i;
            fifo_main_err_o <= |error_flags_i;
        end
    end

    // power-up comes in through reset; dips through the monitor edge
    always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            por_flag <= 1'b1;
        end else if (supply_dip) begin
            por_flag <= 1'b1; // set wins over read clear
        end else if (status_read) begin
            por_flag <= 1'b0;
        end
    end

    // one shared enable, so data and channel never describe different results
    always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            data_reg <= '0;
            result_channel_index <= `AIS_CH_RESET;
        end else if (result_write_i) begin
            data_reg <= result_data_i;
            result_channel_index <= result_channel_i;
        end
    end

    // reads low after reset so the status byte matches its reset value
    always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            result_ready_n <= 1'b0;
        end else if (result_write_i) begin
            result_ready_n <= 1'b0; // new result wins over read
        end else if (data_read_i) begin
            result_ready_n <= 1'b1;
        end
    end

    assign data_o = data_reg;
    assign result_ready_n_o = result_ready_n;

    always_comb begin
        status_o = 8'h00;
        status_o[`AIS_BIT_READY_N] = result_ready_n;
        status_o[`AIS_BIT_ERR] = main_err;
        status_o[`AIS_BIT_POR] = por_flag;
        status_o[`AIS_CH_MSB:0] = result_channel_index;
    end

    // assertions watch the internal flops and some output pins; the bench checks the pins
    chk_err_follows: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
        main_err == (|$past(error_flags_i)))
        else $error("summary error flag does not follow error bits");
    chk_err_copy: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
        main_err == fifo_main_err_o)
        else $error("fifo error copy differs");
    chk_err_autoclear: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
        (error_flags_i == '0) [*2] |-> !main_err)
        else $error("error flag did not clear");
    chk_por_dip_set: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
        supply_dip |=> por_flag)
        else $error("supply dip did not set reset flag");
    chk_por_read_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
        (status_read && !supply_dip) |=> !por_flag)
        else $error("status read did not clear reset flag");
    chk_por_after_reset: assert property (@(posedge ref_clk_i)
        $rose(rst_sync_n) |-> por_flag)
        else $error("reset flag not one after reset");
    chk_chan_capture: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
        result_write_i |=> result_channel_index == $past(result_channel_i)
            && data_reg == $past(result_data_i))
        else $error("channel and data not captured together");
    chk_chan_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
        !result_write_i |=> $stable(result_channel_index))
        else $error("channel field changed without a result");
    chk_ready_cycle: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
        result_write_i ##1 (data_read_i && !result_write_i) |=> result_ready_n)
        else $error("ready flag not restored by data read");
    chk_status_map: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
        status_o[`AIS_BIT_POR] == por_flag && status_o[`AIS_BIT_RSVD] == 1'b0)
        else $error("status layout wrong");

    // values seen at the first edge after reset is released
    chk_status_reset: assert property (@(posedge ref_clk_i)
        $rose(rst_sync_n) |-> status_o == `AIS_STATUS_RESET)
        else $error("status not at reset value after reset");
    chk_err_reset: assert property (@(posedge ref_clk_i)
        $rose(rst_sync_n) |-> !main_err && !fifo_main_err_o)
        else $error("error flags not zero after reset");
    chk_chan_reset: assert property (@(posedge ref_clk_i)
        $rose(rst_sync_n) |-> result_channel_index == `AIS_CH_RESET)
        else $error("channel field not zero after reset");

    // field layout and pin copies
    chk_chan_field: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
        status_o[`AIS_CH_MSB:0] == result_channel_index)
        else $error("channel field not the stored index");
    chk_ready_pin: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
        result_ready_n_o == status_o[`AIS_BIT_READY_N])
        else $error("ready output differs from status bit");
    chk_fifo_follows: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
        fifo_main_err_o == (|$past(error_flags_i)))
        else $error("fifo error copy does not follow error bits");

    // flags hold until their cause, and only their cause moves them
    chk_por_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
        (!status_read && !supply_dip) |=> $stable(por_flag))
        else $error("reset flag changed without a cause");
    chk_por_other_addr: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
        (reg_read_i && (reg_addr_i != `AIS_STATUS_ADDR) && por_flag) |=> por_flag)
        else $error("read of another register cleared reset flag");
    chk_sync_order: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
        supply_low_d == $past(supply_low_s))
        else $error("supply edge detector out of step");
    chk_ready_set: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
        result_write_i |=> !result_ready_n)
        else $error("ready flag not low after new result");
    chk_ready_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
        (!result_write_i && !data_read_i) |=> $stable(result_ready_n))
        else $error("ready flag changed without a cause");
    chk_data_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
        !result_write_i |=> $stable(data_reg))
        else $error("data register changed without a result");

    cov_err_episode: cover property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
        main_err ##[1:20] !main_err);
    cov_por_clear: cover property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
        por_flag ##1 !por_flag);
    cov_ready_read: cover property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
        !result_ready_n ##1 result_ready_n);
    cov_chan_15: cover property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
        result_channel_index == 4'hf);
    cov_por_dip: cover property (@(posedge ref_clk_i) disable iff (!rst_sync_n)
        (supply_dip && !por_flag) ##1 por_flag);
endmodule : adc_interface_status

/* sim/ais_host_model.sv */
/*
 host model: issues register and data-register reads as one-cycle pulses.
 assumes the device samples them on rising edges of ref_clk_i.
*/
`timescale 1ns/1ps
module ais_host_model (
    input wire logic ref_clk_i,
    output logic reg_read_o,
    output logic [5:0] reg_addr_o,
    output logic data_read_o
);
    initial begin
        reg_read_o = 1'b0;
        reg_addr_o = 6'h3f;
        data_read_o = 1'b0;
    end
    task automatic read_reg(input logic [5:0] addr);
        @(negedge ref_clk_i);
        reg_addr_o = addr;
        reg_read_o = 1'b1;
        @(negedge ref_clk_i);
        reg_read_o = 1'b0;
        // released address shows the inverted address, never the old value
        reg_addr_o = ~addr;
    endtask : read_reg
    task automatic read_data();
        @(negedge ref_clk_i);
        data_read_o = 1'b1;
        @(negedge ref_clk_i);
        data_read_o = 1'b0;
    endtask : read_data
endmodule : ais_host_model

/* sim/testbench.sv */
/*
 self-checking bench for the status flag block with a host read model.
 assumes design, package and host model are compiled first.
*/
`timescale 1ns/1ps
module testbench;
    import ais_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [15:0] err_i = 16'h0000;
    logic sup_i = 1'b0;
    logic wr_i = 1'b0;
    logic [15:0] wdata_i = 16'h0000;
    logic [3:0] ch_i = 4'h0;
    logic rd, drd;
    logic [5:0] addr;
    logic [7:0] status;
    logic [15:0] data;
    logic fifo_err, ready_n;
    int err_count = 0;
    int num_checks = 0;
    always #20 ref_clk_i = ~ref_clk_i;
    ais_host_model HOST (.ref_clk_i(ref_clk_i), .reg_read_o(rd), .reg_addr_o(addr),
        .data_read_o(drd));
    adc_interface_status DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .error_flags_i(err_i), .supply_low_i(sup_i), .result_write_i(wr_i),
        .result_data_i(wdata_i), .result_channel_i(ch_i), .reg_read_i(rd),
        .reg_addr_i(addr), .data_read_i(drd), .status_o(status), .data_o(data),
        .fifo_main_err_o(fifo_err), .result_ready_n_o(ready_n));
    task automatic check_status(input logic [7:0] exp);
        num_checks++;
        if (status !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, status, exp);
        end
    endtask : check_status
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val
    task automatic end_sim();
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim
    task automatic wait_neg(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask : wait_neg
    initial begin
        wait_neg(2);
        rst_n_i = 1'b1;
        wait_neg(4);
        check_status(8'h10);
        check_val({15'h0, fifo_err}, 16'h0000);
        check_val({15'h0, ready_n}, 16'h0000);
        HOST.read_reg(6'h01);
        check_status(8'h10);
        HOST.read_reg(6'h00);
        check_status(8'h00);
        err_i = 16'h8000;
        wait_neg(2);
        check_status(8'h40);
        check_val({15'h0, fifo_err}, 16'h0001);
        err_i = 16'h0000;
        wait_neg(2);
        check_status(8'h00);
        check_val({15'h0, fifo_err}, 16'h0000);
        // a result every other cycle: every channel index, ready stays low
        for (int c = 0; c < 16; c++) begin
            @(negedge ref_clk_i);
            wr_i = 1'b1;
            ch_i = c[3:0];
            wdata_i = {12'h5a3, c[3:0]};
            @(negedge ref_clk_i);
            wr_i = 1'b0;
            ch_i = ~c[3:0];
            wdata_i = 16'hffff;
            check_status({4'h0, c[3:0]});
            check_val(data, {12'h5a3, c[3:0]});
            check_val({15'h0, ready_n}, 16'h0000);
        end
        HOST.read_data();
        check_status(8'h8f);
        check_val({15'h0, ready_n}, 16'h0001);
        sup_i = 1'b1;
        wait_neg(5);
        check_status(8'h9f);
        sup_i = 1'b0;
        wait_neg(5);
        HOST.read_reg(6'h00);
        check_status(8'h8f);
        // second reset in mid-run: every reset is a new power-on event
        @(negedge ref_clk_i);
        rst_n_i = 1'b0;
        wait_neg(2);
        rst_n_i = 1'b1;
        wait_neg(4);
        check_status(8'h10);
        check_val(data, 16'h0000);
        end_sim();
    end
    initial begin
        #(40 * 2000);
        err_count++;
        end_sim();
    end
endmodule : testbench
